// file: hw/pssa_defines.svh
`ifndef PSSA_DEFINES_SVH
`define PSSA_DEFINES_SVH

// Clock and time base
`define PSSA_CLK_MHZ        125
`define PSSA_TICKS_PER_SEC  125000000
`define PSSA_SYNC_WIN_S     3
`define PSSA_SYNC_WIN_CYC   (`PSSA_SYNC_WIN_S * `PSSA_TICKS_PER_SEC)
`define PSSA_REF_PER_SEC    10000000
`define PSSA_REF_W          24
`define PSSA_SEC_W          32
`define PSSA_SLEW_W         32
`define PSSA_OFS_W          21
`define PSSA_OFS_MAX        21'sd999999
`define PSSA_OFS_MIN        (-21'sd999999)
`define PSSA_SLEW_OFS       21'sd1000000
`define PSSA_FOFS_W         22
`define PSSA_ALM_RESTART    8'h16
`define PSSA_ALM_NONE       8'h00
`define PSSA_ALM_SLOTS      5
`define PSSA_PPS_WIDTH      24'd200

`endif

// file: hw/pssa_pkg.sv
package pssa_pkg;
	typedef enum logic [1:0] {
		PSSA_ST_OPER  = 2'b00,
		PSSA_ST_WARM  = 2'b01,
		PSSA_ST_MINOR = 2'b10,
		PSSA_ST_MAJOR = 2'b11
	} pssa_state_t;

	typedef enum logic [1:0] {
		PSSA_SL_IDLE = 2'b00,
		PSSA_SL_ADV  = 2'b01,
		PSSA_SL_RET  = 2'b10
	} pssa_slew_t;
endpackage : pssa_pkg

// file: hw/pssa_alarm_list.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssa_defines.svh"

// ************************************************
// Five-slot alarm list, registered read
// ************************************************
module pssa_alarm_list (
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_ce,
	input  wire logic       i_clear,
	input  wire logic       i_add,
	input  wire logic [7:0] i_code,
	output logic      [39:0] o_list
);
	logic [39:0] list_d, list_q;
	logic        present;
	logic        placed;

	always_comb begin
		list_d  = list_q;
		present = 1'b0;
		placed  = 1'b0;
		if (i_clear) begin
			list_d = '0;
		end
		for (int i = 0; i < `PSSA_ALM_SLOTS; i++) begin
			if (list_d[i*8 +: 8] == i_code) begin
				present = 1'b1;
			end
		end
		if (i_add && !present) begin
			for (int i = 0; i < `PSSA_ALM_SLOTS; i++) begin
				if (!placed && list_d[i*8 +: 8] == `PSSA_ALM_NONE) begin
					list_d[i*8 +: 8] = i_code;
					placed = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			list_q <= '0;
		end else if (i_ce) begin
			list_q <= list_d;
		end
	end

	assign o_list = list_q;
endmodule : pssa_alarm_list
`default_nettype wire

// file: hw/pssa_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssa_defines.svh"

module pssa_ctrl (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic                     i_ce,
	input  wire logic                     i_ref_tick,
	input  wire logic                     i_pulse_align_input,
	input  wire logic                     i_ofs_wr,
	input  wire logic signed [20:0]       i_ofs_val,
	input  wire logic                     i_sync_cmd,
	input  wire logic                     i_slew_start,
	input  wire logic                     i_slew_adv,
	input  wire logic [31:0]              i_slew_ns,
	input  wire logic                     i_slew_abort,
	input  wire logic                     i_locked,
	input  wire logic                     i_minor_cond,
	input  wire logic [7:0]               i_minor_code,
	input  wire logic                     i_major_cond,
	input  wire logic [7:0]               i_major_code,
	input  wire logic                     i_alarm_reset,
	input  wire logic                     i_policy_strict,
	output logic signed [21:0]            o_freq_ofs,
	output logic                          o_pps,
	output logic                          o_outputs_en,
	output logic                          o_led_fault,
	output logic                          o_led_lock,
	output logic                          o_slew_busy,
	output logic                          o_sync_busy,
	output pssa_pkg::pssa_state_t         o_state,
	output logic [39:0]                   o_alarm_list
);
	import pssa_pkg::*;

	// ************************************************
	// Registers
	// ************************************************
	logic signed [20:0] prog_d, prog_q;
	logic signed [21:0] fofs_d, fofs_q;
	logic [23:0]        div_d, div_q;
	logic               pps_d, pps_q;
	logic               align_d, align_q;
	logic               sync_d, sync_q;
	logic [31:0]        win_d, win_q;
	pssa_slew_t         sl_d, sl_q;
	logic [31:0]        slcnt_d, slcnt_q;
	logic [26:0]        sec_d, sec_q;
	logic               rflag_d, rflag_q;
	logic               rpend_d, rpend_q;
	logic               busy_d, busy_q;
	logic               major_d, major_q;
	logic               en_d, en_q;
	logic               fault_d, fault_q;
	logic               lock_d, lock_q;
	pssa_state_t        st_d, st_q;
	logic               clr_list;
	logic               add_alm;
	logic [7:0]         add_code;

	function automatic logic signed [20:0] clamp_ofs(
		input logic signed [20:0] v);
		if (v > `PSSA_OFS_MAX) begin
			return `PSSA_OFS_MAX;
		end else if (v < `PSSA_OFS_MIN) begin
			return `PSSA_OFS_MIN;
		end
		return v;
	endfunction : clamp_ofs

	// ************************************************
	// Frequency, pulse and phase control
	// ************************************************
	always_comb begin
		prog_d  = prog_q;
		div_d   = div_q;
		pps_d   = pps_q;
		sync_d  = sync_q;
		win_d   = win_q;
		sl_d    = sl_q;
		slcnt_d = slcnt_q;
		sec_d   = sec_q;
		align_d = i_pulse_align_input;
		if (i_ofs_wr) begin
			prog_d = clamp_ofs(i_ofs_val);
		end
		if (i_ref_tick) begin
			if (div_q == 24'(`PSSA_REF_PER_SEC - 1)) begin
				div_d = '0;
			end else begin
				div_d = div_q + 24'd1;
			end
		end
		pps_d = (div_d < `PSSA_PPS_WIDTH) && en_q;
		if (i_sync_cmd) begin
			sync_d = 1'b1;
			win_d  = '0;
		end else if (sync_q) begin
			if (i_pulse_align_input && !align_q) begin
				div_d  = '0;
				pps_d  = en_q;
				sync_d = 1'b0;
			end else if (win_q == 32'(`PSSA_SYNC_WIN_CYC - 1)) begin
				sync_d = 1'b0;
			end else begin
				win_d = win_q + 32'd1;
			end
		end
		if (i_slew_abort) begin
			sl_d = PSSA_SL_IDLE;
		end else if (i_slew_start && i_slew_ns != '0) begin
			sl_d    = i_slew_adv ? PSSA_SL_ADV : PSSA_SL_RET;
			slcnt_d = i_slew_ns;
			sec_d   = '0;
		end else if (sl_q != PSSA_SL_IDLE) begin
			if (sec_q == 27'(`PSSA_TICKS_PER_SEC - 1)) begin
				sec_d = '0;
				if (slcnt_q == 32'd1) begin
					sl_d = PSSA_SL_IDLE;
				end
				slcnt_d = slcnt_q - 32'd1;
			end else begin
				sec_d = sec_q + 27'd1;
			end
		end
		unique case (sl_d)
			PSSA_SL_ADV:  fofs_d = 22'(prog_d) + 22'(`PSSA_SLEW_OFS);
			PSSA_SL_RET:  fofs_d = 22'(prog_d) - 22'(`PSSA_SLEW_OFS);
			default:      fofs_d = 22'(prog_d);
		endcase
		busy_d = (sl_d != PSSA_SL_IDLE);
	end

	// ************************************************
	// Alarms and output muting
	// ************************************************
	always_comb begin
		rflag_d  = rflag_q;
		rpend_d  = rpend_q;
		major_d  = major_q;
		clr_list = i_alarm_reset;
		add_alm  = 1'b0;
		add_code = `PSSA_ALM_RESTART;
		if (i_alarm_reset) begin
			rflag_d = 1'b0;
			rpend_d = 1'b0;
		end
		if (i_major_cond) begin
			major_d  = 1'b1;
			add_alm  = 1'b1;
			add_code = i_major_code;
		end else if (major_q) begin
			major_d  = 1'b0;
			rflag_d  = 1'b1;
			rpend_d  = 1'b1;
		end else if (rpend_q) begin
			// Restart code enters once, minor codes not starved
			add_alm  = 1'b1;
			add_code = `PSSA_ALM_RESTART;
			rpend_d  = 1'b0;
		end else if (i_minor_cond) begin
			add_alm  = 1'b1;
			add_code = i_minor_code;
		end
		// Cleared list refills from the next cycle on
		if (i_alarm_reset) begin
			add_alm = 1'b0;
		end
		en_d = i_locked && !major_d
			&& !(i_policy_strict && rflag_d);
		fault_d = i_major_cond || i_minor_cond;
		lock_d  = i_locked && !major_d;
		if (major_d) begin
			st_d = PSSA_ST_MAJOR;
		end else if (!i_locked) begin
			st_d = PSSA_ST_WARM;
		end else if (i_minor_cond) begin
			st_d = PSSA_ST_MINOR;
		end else begin
			st_d = PSSA_ST_OPER;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prog_q  <= '0;
			fofs_q  <= '0;
			div_q   <= '0;
			pps_q   <= 1'b0;
			align_q <= 1'b0;
			sync_q  <= 1'b0;
			win_q   <= '0;
			sl_q    <= PSSA_SL_IDLE;
			slcnt_q <= '0;
			sec_q   <= '0;
			rflag_q <= 1'b1;
			rpend_q <= 1'b1;
			busy_q  <= 1'b0;
			major_q <= 1'b0;
			en_q    <= 1'b0;
			fault_q <= 1'b0;
			lock_q  <= 1'b0;
			st_q    <= PSSA_ST_WARM;
		end else if (i_ce) begin
			prog_q  <= prog_d;
			fofs_q  <= fofs_d;
			div_q   <= div_d;
			pps_q   <= pps_d;
			align_q <= align_d;
			sync_q  <= sync_d;
			win_q   <= win_d;
			sl_q    <= sl_d;
			slcnt_q <= slcnt_d;
			sec_q   <= sec_d;
			rflag_q <= rflag_d;
			rpend_q <= rpend_d;
			busy_q  <= busy_d;
			major_q <= major_d;
			en_q    <= en_d;
			fault_q <= fault_d;
			lock_q  <= lock_d;
			st_q    <= st_d;
		end
	end

	pssa_alarm_list u_list (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_ce       (i_ce),
		.i_clear    (clr_list),
		.i_add      (add_alm),
		.i_code     (add_code),
		.o_list     (o_alarm_list)
	);

	assign o_freq_ofs   = fofs_q;
	assign o_pps        = pps_q;
	assign o_outputs_en = en_q;
	assign o_led_fault  = fault_q;
	assign o_led_lock   = lock_q;
	assign o_slew_busy  = busy_q;
	assign o_sync_busy  = sync_q;
	assign o_state      = st_q;
endmodule : pssa_ctrl
`default_nettype wire

// file: verification/pssa_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module pssa_ctrl_chk (
	input wire logic               i_core_clk,
	input wire logic               i_sys_rst,
	input wire logic               i_ce,
	input wire logic               i_ofs_wr,
	input wire logic               i_slew_start,
	input wire logic               i_slew_adv,
	input wire logic [31:0]        i_slew_ns,
	input wire logic               i_slew_abort,
	input wire logic               i_pulse_align_input,
	input wire logic               i_minor_cond,
	input wire logic               i_major_cond,
	input wire logic signed [21:0] o_freq_ofs,
	input wire logic               o_pps,
	input wire logic               o_outputs_en,
	input wire logic               o_led_fault,
	input wire logic               o_led_lock,
	input wire logic               o_slew_busy,
	input wire logic               o_sync_busy,
	input wire pssa_pkg::pssa_state_t o_state
);
	import pssa_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	wire logic go = i_ce && i_slew_start && i_slew_ns != 32'h0
		&& !i_slew_abort && !i_ofs_wr && !o_slew_busy;
	sequence s_edge;
		i_ce && o_sync_busy && $rose(i_pulse_align_input);
	endsequence
	sequence s_major;
		i_ce && i_major_cond;
	endsequence
	a_slew_adv: assert property (go && i_slew_adv |=> o_slew_busy
		&& o_freq_ofs == $past(o_freq_ofs) + 22'sh0f4240)
		else $error("advance offset wrong");
	a_slew_ret: assert property (go && !i_slew_adv |=> o_slew_busy
		&& o_freq_ofs == $past(o_freq_ofs) - 22'sh0f4240)
		else $error("retard offset wrong");
	a_abort_ends: assert property (i_ce && i_slew_abort |=> !o_slew_busy)
		else $error("abort did not end slew");
	a_ofs_range: assert property (!o_slew_busy |-> o_freq_ofs <= 22'sh0f423f
		&& o_freq_ofs >= -22'sh0f423f) else $error("offset out of range");
	a_sync_edge: assert property (s_edge |-> ##[1:2] !o_sync_busy)
		else $error("sync not ended by edge");
	a_major_state: assert property (s_major |-> ##[1:2] o_state == PSSA_ST_MAJOR)
		else $error("major state code wrong");
	a_major_mute: assert property (s_major |-> ##[1:2] (!o_outputs_en
		&& !o_led_lock && o_led_fault)) else $error("major outputs not off");
	a_minor_fault: assert property (i_ce && i_minor_cond |-> ##[1:2] o_led_fault)
		else $error("fault lamp not lit");
	a_pps_gated: assert property (o_pps |-> o_outputs_en || $past(o_outputs_en))
		else $error("pulse while muted");
endmodule : pssa_ctrl_chk
bind pssa_ctrl pssa_ctrl_chk u_chk (.i_core_clk, .i_sys_rst, .i_ce, .i_ofs_wr,
	.i_slew_start, .i_slew_adv, .i_slew_ns, .i_slew_abort, .i_pulse_align_input,
	.i_minor_cond, .i_major_cond, .o_freq_ofs, .o_pps, .o_outputs_en,
	.o_led_fault, .o_led_lock, .o_slew_busy, .o_sync_busy, .o_state);
`default_nettype wire

// file: verification/pssa_ref_src.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Reference tick and align pulse source
// ****************************************
module pssa_ref_src (
	input  wire logic i_core_clk,
	input  wire logic i_fire,
	output logic      o_ref_tick,
	output logic      o_align
);
	logic [3:0]  div_q = 4'h0;
	logic [11:0] wid_q = 12'h0;
	always @(posedge i_core_clk) begin
		div_q <= (div_q == 4'hc) ? 4'h0 : div_q + 4'h1;
		wid_q <= i_fire ? 12'h9c4 : (wid_q != 12'h0 ? wid_q - 12'h1 : 12'h0);
	end
	assign o_ref_tick = (div_q == 4'hc);
	assign o_align    = (wid_q != 12'h0);
endmodule : pssa_ref_src
`default_nettype wire

// file: verification/tb_pssa_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pssa_ctrl;
	import pssa_pkg::*;
	logic clk = 0, rst = 1, lk = 0, mi = 0, ma = 0, ar = 0, sx = 0, fire = 0;
	logic wr = 0, go = 0, adv = 0, ab = 0, sy = 0, ce = 1;
	logic signed [20:0] ov = 0;
	logic signed [21:0] fo;
	logic pps, oen, flt, lck, sb, yb, tk, al;
	pssa_state_t st;
	logic [39:0] lst;
	int miscompares = 0, compares = 0, n;
	always #4 clk = ~clk;
	pssa_ref_src u_src (.i_core_clk(clk), .i_fire(fire), .o_ref_tick(tk),
		.o_align(al));
	pssa_ctrl dut (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce),
		.i_ref_tick(tk), .i_pulse_align_input(al), .i_ofs_wr(wr),
		.i_ofs_val(ov), .i_sync_cmd(sy), .i_slew_start(go), .i_slew_adv(adv),
		.i_slew_ns(32'h5), .i_slew_abort(ab), .i_locked(lk), .i_minor_cond(mi),
		.i_minor_code(8'h21), .i_major_cond(ma), .i_major_code(8'h33),
		.i_alarm_reset(ar), .i_policy_strict(sx), .o_freq_ofs(fo), .o_pps(pps),
		.o_outputs_en(oen), .o_led_fault(flt), .o_led_lock(lck),
		.o_slew_busy(sb), .o_sync_busy(yb), .o_state(st), .o_alarm_list(lst));
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task close_out;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task t_restart;
		tick(12);
		chk(st, 2'b01);
		rst = 0; tick(3);
		chk(lst, 40'h16);
		chk(oen, 1'b0);
		lk = 1; tick(3);
		chk(oen, 1'b1);
		chk(lck, 1'b1);
		chk(lst, 40'h16);
	endtask : t_restart
	task t_offset;
		ov = 21'sh0f4240; wr = 1; tick(1); wr = 0; tick(2);
		chk(fo, 22'sh0f423f);
		ov = -21'sh5; wr = 1; tick(1); wr = 0; tick(2);
		chk(fo, -22'sh5);
		ce = 0; ov = 21'sh7; wr = 1; tick(1); wr = 0; ce = 1; tick(2);
		chk(fo, -22'sh5);
	endtask : t_offset
	task t_slew(input logic a, input logic signed [21:0] e);
		adv = a; go = 1; tick(1); go = 0; tick(2);
		chk(sb, 1'b1);
		chk(fo, e);
		ab = 1; tick(1); ab = 0; tick(2);
		chk(sb, 1'b0);
		chk(fo, -22'sh5);
	endtask : t_slew
	task t_sync;
		tick(1300);
		sy = 1; tick(1); sy = 0; tick(2);
		chk(yb, 1'b1);
		fire = 1; tick(1); fire = 0;
		for (n = 0; n < 20 && yb !== 1'b0; n++) tick(1);
		chk(yb, 1'b0);
		if (yb !== 1'b0) close_out();
		tick(2400);
		chk(pps, 1'b1);
		tick(300);
		chk(pps, 1'b0);
	endtask : t_sync
	task t_minor;
		mi = 1; tick(3);
		chk({flt, oen, st}, 4'b1110);
		chk(lst, 40'h2116);
		mi = 0; ar = 1; tick(1); ar = 0; tick(3);
		chk(lst, 40'h0);
		chk({flt, st}, 3'b000);
	endtask : t_minor
	task t_major;
		ma = 1; tick(3);
		chk({oen, lck, flt, st}, 5'b00111);
		ma = 0; tick(4);
		chk(lst, 40'h1633);
		chk(oen, 1'b1);
	endtask : t_major
	task t_strict;
		sx = 1; tick(3);
		chk(oen, 1'b0);
		ar = 1; tick(1); ar = 0; tick(3);
		chk(oen, 1'b1);
		chk(lst, 40'h0);
	endtask : t_strict
	initial begin
		#1;
		t_restart();
		t_offset();
		t_slew(1'b1, 22'sh0f423b);
		t_slew(1'b0, -22'sh0f4245);
		t_sync();
		t_minor();
		t_major();
		t_strict();
		close_out();
	end
endmodule : tb_pssa_ctrl
`default_nettype wire
